// file: src/spr_controller.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - relay one makes only after alarm held unbroken for make delay, 0..9999 s
// - relay one breaks only after non-alarm held unbroken for break delay
// - relays two to four follow their comparisons with no delay
// - band enabled, second above first, code LhLh or hhhh: band from first up to second
// - filling code LhLh: on below first, stays on until second reached
// - emptying code hhhh: on above second, stays on until first reached
// - high direction energizes above threshold, low direction below it
// - code letters first to fourth left to right, four legal combinations
// - thresholds without relays still drive their indicator outputs
// - lock input tied low keeps settings readable but refuses writes; interrupt status clears still go through
module spr_controller (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] reading_i,
    input wire logic reading_valid_i,
    input wire logic lock_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic [3:0] relay_o,
    output logic [3:0] indicator_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    logic [15:0] threshold_first;
    logic [15:0] threshold_second;
    logic [15:0] threshold_third;
    logic [15:0] threshold_fourth;
    logic [13:0] make_delay;
    logic [13:0] break_delay;
    spr_pkg::spr_code_t relay_direction_code;
    logic band_enable;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [15:0] reading;
    logic [3:0] cmp;
    logic band_latch;
    logic alarm_first;
    logic relay_first;
    logic [3:0] next_relay;
    logic [3:0] irq_clr;
    logic [31:0] tick_cnt;
    logic tick;
    logic lock_meta;
    logic lock_sync_n;
    spr_pkg::spr_bus_req_t req;
    logic wr_ok;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // signed comparison, readings span -1999..9999
    function automatic logic above(input logic [15:0] a, input logic [15:0] b);
        above = $signed(a) > $signed(b);
    endfunction : above

    function automatic logic below(input logic [15:0] a, input logic [15:0] b);
        below = $signed(a) < $signed(b);
    endfunction : below

    function automatic logic [13:0] clamp_delay(input logic [15:0] v);
        clamp_delay = (v > {2'b00, spr_pkg::MAX_DELAY}) ? spr_pkg::MAX_DELAY : v[13:0];
    endfunction : clamp_delay

    // ------------------------------------------------------------
    // lock pin synchroniser
    // ------------------------------------------------------------
    // the pin is outside our domain, so two stages before any use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_meta <= 1'b1;
            lock_sync_n <= 1'b1;
        end else begin
            lock_meta <= lock_n_i;
            lock_sync_n <= lock_meta;
        end
    end

    assign wr_ok = req.wr && lock_sync_n; // tied to common refuses writes except interrupt status clears

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // refused writes are dropped silently; reads still work
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            threshold_first <= spr_pkg::RST_THRESHOLD_HIGH;
            threshold_second <= spr_pkg::RST_THRESHOLD_HIGH;
            threshold_third <= spr_pkg::RST_THRESHOLD_HIGH;
            threshold_fourth <= spr_pkg::RST_THRESHOLD_HIGH;
            make_delay <= spr_pkg::RST_DELAY;
            break_delay <= spr_pkg::RST_DELAY;
            relay_direction_code <= spr_pkg::SPR_CODE_HHHH;
            band_enable <= 1'b0;
            irq_mask <= 4'h0;
        end else if (wr_ok) begin
            case (req.addr)
                spr_pkg::ADDR_THRESHOLD_FIRST: threshold_first <= req.wdata;
                spr_pkg::ADDR_THRESHOLD_SECOND: threshold_second <= req.wdata;
                spr_pkg::ADDR_THRESHOLD_THIRD: threshold_third <= req.wdata;
                spr_pkg::ADDR_THRESHOLD_FOURTH: threshold_fourth <= req.wdata;
                spr_pkg::ADDR_MAKE_DELAY: make_delay <= clamp_delay(req.wdata);
                spr_pkg::ADDR_BREAK_DELAY: break_delay <= clamp_delay(req.wdata);
                spr_pkg::ADDR_MODE: begin
                    // only the four legal codes are encodable
                    relay_direction_code <= spr_pkg::spr_code_t'(req.wdata[1:0]);
                    band_enable <= req.wdata[spr_pkg::MODE_BAND_BIT];
                end
                spr_pkg::ADDR_IRQ_MASK: irq_mask <= req.wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // reading capture and one second tick
    // ------------------------------------------------------------
    // a new comparison happens only when a fresh result arrives or a setting is written
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reading <= 16'h0000;
        end else if (reading_valid_i) begin
            reading <= reading_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (tick_cnt == 32'(spr_pkg::TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // comparisons
    // ------------------------------------------------------------
    // letter i of the code is high when bit set; left letter is first
    always_comb begin
        logic [3:0] hi;
        hi = 4'h0;
        case (relay_direction_code)
            spr_pkg::SPR_CODE_LLLL: hi = 4'b0000;
            spr_pkg::SPR_CODE_LHLH: hi = 4'b1010;
            spr_pkg::SPR_CODE_LHHH: hi = 4'b1110;
            spr_pkg::SPR_CODE_HHHH: hi = 4'b1111;
            default: hi = 4'b0000;
        endcase
        cmp[0] = hi[0] ? above(reading, threshold_first) : below(reading, threshold_first);
        cmp[1] = hi[1] ? above(reading, threshold_second)
                       : below(reading, threshold_second);
        cmp[2] = hi[2] ? above(reading, threshold_third)
                       : below(reading, threshold_third);
        cmp[3] = hi[3] ? above(reading, threshold_fourth)
                       : below(reading, threshold_fourth);
    end

    // band latch: always tracks, steers relay one only with enable, second above first and code LHLH or HHHH
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            band_latch <= 1'b0;
        end else if (relay_direction_code == spr_pkg::SPR_CODE_LHLH) begin
            if (below(reading, threshold_first)) begin
                band_latch <= 1'b1; // filling starts below first
            end else if (!below(reading, threshold_second)) begin
                band_latch <= 1'b0; // stops once second reached
            end
        end else begin
            if (above(reading, threshold_second)) begin
                band_latch <= 1'b1; // emptying starts above second
            end else if (!above(reading, threshold_first)) begin
                band_latch <= 1'b0; // stops once first reached
            end
        end
    end

    always_comb begin
        if (band_enable && above(threshold_second, threshold_first) &&
            (relay_direction_code == spr_pkg::SPR_CODE_LHLH ||
             relay_direction_code == spr_pkg::SPR_CODE_HHHH)) begin
            alarm_first = band_latch;
        end else begin
            alarm_first = cmp[0];
        end
    end

    // ------------------------------------------------------------
    // first relay delay timers
    // ------------------------------------------------------------
    spr_delay_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .alarm_i(alarm_first),
        .make_delay_i(make_delay),
        .break_delay_i(break_delay),
        .relay_o(relay_first)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // relays two to four follow comparison directly
    assign next_relay = {cmp[3], cmp[2], cmp[1], relay_first};

    // indicators driven even where no relay is fitted
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_o <= 4'h0;
            indicator_o <= 4'h0;
        end else begin
            relay_o <= next_relay;
            indicator_o <= next_relay;
        end
    end

    // status sticky bits: set on any relay change, write one to clear; set wins
    assign irq_clr = (req.wr && req.addr == spr_pkg::ADDR_IRQ_STATUS) ? req.wdata[3:0] : 4'h0;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status <= 4'h0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | (next_relay ^ relay_o);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // unmapped addresses read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (req.rd) begin
            case (req.addr)
                spr_pkg::ADDR_THRESHOLD_FIRST: rdata_o <= threshold_first;
                spr_pkg::ADDR_THRESHOLD_SECOND: rdata_o <= threshold_second;
                spr_pkg::ADDR_THRESHOLD_THIRD: rdata_o <= threshold_third;
                spr_pkg::ADDR_THRESHOLD_FOURTH: rdata_o <= threshold_fourth;
                spr_pkg::ADDR_MAKE_DELAY: rdata_o <= {2'b00, make_delay};
                spr_pkg::ADDR_BREAK_DELAY: rdata_o <= {2'b00, break_delay};
                spr_pkg::ADDR_MODE: rdata_o <= {13'h0000, band_enable, relay_direction_code};
                spr_pkg::ADDR_STATUS: rdata_o <= {7'h00, ~lock_sync_n, band_latch,
                                                  relay_o, 3'b000};
                spr_pkg::ADDR_IRQ_STATUS: rdata_o <= {12'h000, irq_status};
                spr_pkg::ADDR_IRQ_MASK: rdata_o <= {12'h000, irq_mask};
                spr_pkg::ADDR_READING: rdata_o <= reading;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

endmodule : spr_controller

// file: src/spr_delay_timer.sv
`timescale 1ns/10ps
// delay-on-make / delay-on-break qualifier for the first relay
module spr_delay_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic alarm_i,
    input wire logic [13:0] make_delay_i,
    input wire logic [13:0] break_delay_i,
    output logic relay_o
);

    spr_pkg::spr_state_t state;
    logic [13:0] secs;

    // ------------------------------------------------------------
    // state and seconds counter
    // ------------------------------------------------------------
    // a zero delay acts in the same cycle, so no tick wait is added
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= spr_pkg::SPR_OFF;
            secs <= spr_pkg::RST_DELAY;
        end else begin
            case (state)
                spr_pkg::SPR_OFF: begin
                    secs <= spr_pkg::RST_DELAY;
                    if (alarm_i) begin
                        state <= (make_delay_i == 14'h0000) ? spr_pkg::SPR_ON
                                                            : spr_pkg::SPR_MAKING;
                    end
                end
                spr_pkg::SPR_MAKING: begin
                    if (!alarm_i) begin
                        state <= spr_pkg::SPR_OFF; // interruption restarts
                        secs <= spr_pkg::RST_DELAY;
                    end else if (secs > make_delay_i) begin
                        state <= spr_pkg::SPR_ON; // n whole seconds
                        secs <= spr_pkg::RST_DELAY;
                    end else if (tick_i) begin
                        secs <= secs + 14'h0001;
                    end
                end
                spr_pkg::SPR_ON: begin
                    secs <= spr_pkg::RST_DELAY;
                    if (!alarm_i) begin
                        state <= (break_delay_i == 14'h0000) ? spr_pkg::SPR_OFF
                                                             : spr_pkg::SPR_BREAKING;
                    end
                end
                spr_pkg::SPR_BREAKING: begin
                    if (alarm_i) begin
                        state <= spr_pkg::SPR_ON; // back in alarm restarts
                        secs <= spr_pkg::RST_DELAY;
                    end else if (secs > break_delay_i) begin
                        state <= spr_pkg::SPR_OFF; // first tick may be partial
                        secs <= spr_pkg::RST_DELAY;
                    end else if (tick_i) begin
                        secs <= secs + 14'h0001;
                    end
                end
                default: begin
                    state <= spr_pkg::SPR_OFF;
                end
            endcase
        end
    end

    // relay held through the break wait, released through the make wait
    always_comb begin
        relay_o = (state == spr_pkg::SPR_ON) || (state == spr_pkg::SPR_BREAKING);
    end

endmodule : spr_delay_timer

// file: src/spr_pkg.sv
package spr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_THRESHOLD_FIRST = 4'h0;
    localparam logic [3:0] ADDR_THRESHOLD_SECOND = 4'h1;
    localparam logic [3:0] ADDR_THRESHOLD_THIRD = 4'h2;
    localparam logic [3:0] ADDR_THRESHOLD_FOURTH = 4'h3;
    localparam logic [3:0] ADDR_MAKE_DELAY = 4'h4;
    localparam logic [3:0] ADDR_BREAK_DELAY = 4'h5;
    localparam logic [3:0] ADDR_MODE = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
    localparam logic [3:0] ADDR_READING = 4'hA;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int MODE_CODE_LSB = 0;
    localparam int MODE_BAND_BIT = 2;
    localparam logic [15:0] RST_THRESHOLD_HIGH = 16'h270F;
    localparam logic [15:0] RST_THRESHOLD_LOW = 16'hF831;
    localparam logic [13:0] RST_DELAY = 14'h0000;
    localparam logic [13:0] MAX_DELAY = 14'h270F;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 250_000_000;
    localparam longint TICK_PERIOD_NS = 1_000_000_000;
    localparam longint CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPR_CODE_LLLL,
        SPR_CODE_LHLH,
        SPR_CODE_LHHH,
        SPR_CODE_HHHH
    } spr_code_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } spr_bus_req_t;

    typedef enum logic [1:0] {
        SPR_OFF,
        SPR_MAKING,
        SPR_ON,
        SPR_BREAKING
    } spr_state_t;

endpackage : spr_pkg

// file: test/spr_controller_properties.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checks of the setpoint relay controller
// ------------------------------------------------------------
module spr_controller_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] reading_i,
    input wire logic reading_valid_i,
    input wire logic lock_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [3:0] relay_o,
    input wire logic [3:0] indicator_o,
    input wire logic irq_o
);
    logic [2:0] quiet_cnt;
    logic mask_seen;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // cycles since the last reading or write; saturates so it never wraps
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_cnt <= 3'h7;
        end else if (reading_valid_i || wr_i) begin
            quiet_cnt <= 3'h0;
        end else if (quiet_cnt != 3'h7) begin
            quiet_cnt <= quiet_cnt + 3'h1;
        end
    end

    // mask resets to zero, so the line cannot rise before software opens it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_seen <= 1'b0;
        end else if (wr_i && addr_i == spr_pkg::ADDR_IRQ_MASK && wdata_i != 16'h0000) begin
            mask_seen <= 1'b1;
        end
    end

    sequence s_unlocked;
        lock_n_i [*3];
    endsequence

    a_ind_match: assert property (indicator_o == relay_o)
        else $error("indicators differ from relays");
    a_relay_settle: assert property ($changed(relay_o[3:1]) |-> quiet_cnt <= 3'h3)
        else $error("relay changed without a recent cause");
    a_reading_readback: assert property (reading_valid_i ##1 (rd_i && !reading_valid_i
        && addr_i == spr_pkg::ADDR_READING) |=> rdata_o == $past(reading_i, 2))
        else $error("stored reading differs from captured value");
    a_write_readback: assert property ((s_unlocked ##0 (wr_i
        && addr_i == spr_pkg::ADDR_THRESHOLD_FIRST)) ##1 (rd_i
        && addr_i == spr_pkg::ADDR_THRESHOLD_FIRST) |=> rdata_o == $past(wdata_i, 2))
        else $error("threshold write not read back");
    a_lock_refuse: assert property (((!lock_n_i) [*3] ##0 (rd_i
        && addr_i == spr_pkg::ADDR_THRESHOLD_FIRST)) ##1 (wr_i && !lock_n_i
        && addr_i == spr_pkg::ADDR_THRESHOLD_FIRST) ##1 (rd_i
        && addr_i == spr_pkg::ADDR_THRESHOLD_FIRST) |=> rdata_o == $past(rdata_o, 2))
        else $error("locked threshold was modified");
    a_rdata_idle: assert property (rdata_o != 16'h0000 |-> $past(rd_i))
        else $error("read data outside its cycle");
    a_unmapped_read: assert property (rd_i && addr_i > spr_pkg::ADDR_READING
        |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (irq_o |-> mask_seen)
        else $error("interrupt raised with mask closed");

    c_relay_first: cover property ($rose(relay_o[0]));
    c_irq_rise: cover property ($rose(irq_o));
    c_lock_write: cover property ((!lock_n_i) [*3] ##0 wr_i);
endmodule : spr_controller_properties

// file: test/spr_controller_tb.sv
`timescale 1ns/10ps
module spr_controller_tb;
    logic clk_i, rst_i, reading_valid_i, lock_n_i, wr_i, rd_i, irq_o;
    logic [15:0] reading_i, wdata_i, rdata_o, d0, d1;
    logic [3:0] addr_i, relay_o, indicator_o, coil_o, lamp_o;
    logic signed [15:0] thr [4];
    logic [15:0] rtab [3] = '{16'hF831, 16'h00FA, 16'h01F4};
    logic [15:0] ftab [5] = '{16'h0032, 16'h0096, 16'h00FA, 16'h0096, 16'h0032};
    logic [4:0] pat = 5'h13;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    spr_controller i_spr_controller (.clk_i(clk_i), .rst_i(rst_i), .reading_i(reading_i),
        .reading_valid_i(reading_valid_i), .lock_n_i(lock_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .relay_o(relay_o), .indicator_o(indicator_o), .irq_o(irq_o));
    spr_panel_model i_spr_panel_model (.clk_i(clk_i), .rst_i(rst_i), .relay_i(relay_o),
        .indicator_i(indicator_o), .coil_o(coil_o), .lamp_o(lamp_o));

    // ------------------------------------------------------------
    // clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // whole run needs a few hundred cycles; anything far beyond is a hang
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic check_outs(input logic [3:0] e);
        check({12'h000, relay_o}, {12'h000, e});
        check({12'h000, lamp_o}, {12'h000, e});
        check({12'h000, coil_o}, {12'h000, e});
    endtask : check_outs

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= w;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d0 = rdata_o;
    endtask : rd
    // read, write, read back to back on one address
    task automatic trio(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        wr_i <= 1'b1;
        wdata_i <= w;
        #1 d0 = rdata_o;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d1 = rdata_o;
    endtask : trio
    // relay one passes compare, band latch and timer, so allow six edges
    task automatic feed(input logic [15:0] r);
        @(posedge clk_i);
        reading_i <= r;
        reading_valid_i <= 1'b1;
        @(posedge clk_i);
        reading_valid_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= spr_pkg::ADDR_READING;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, r);
        repeat (4) @(posedge clk_i);
        #1;
    endtask : feed
    task automatic set_thr(input logic [15:0] a, b, c, d);
        thr[0] = a;
        thr[1] = b;
        thr[2] = c;
        thr[3] = d;
        for (int i = 0; i < 4; i++) begin
            wr(spr_pkg::ADDR_THRESHOLD_FIRST + 4'(i), thr[i]);
        end
    endtask : set_thr
    function automatic logic [3:0] exp_dir(input logic [1:0] code, input logic signed [15:0] r);
        logic [3:0] hi;
        logic [3:0] e;
        hi = (code == 2'h0) ? 4'h0 : (code == 2'h1) ? 4'hA : (code == 2'h2) ? 4'hE : 4'hF;
        for (int i = 0; i < 4; i++) begin
            e[i] = hi[i] ? (r > thr[i]) : (r < thr[i]);
        end
        return e;
    endfunction : exp_dir

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        reading_i = 16'h0000;
        reading_valid_i = 1'b0;
        lock_n_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            rd(spr_pkg::ADDR_THRESHOLD_FIRST + 4'(i));
            check(d0, spr_pkg::RST_THRESHOLD_HIGH);
        end
        rd(spr_pkg::ADDR_MODE);
        check(d0, 16'h0003);
        rd(spr_pkg::ADDR_IRQ_MASK);
        check(d0, 16'h0000);
        rd(4'hF);
        check(d0, 16'h0000);
        check_outs(4'h0);
        $display("test reset done");
        // every direction code against readings below, between and above
        set_thr(16'h0064, 16'h00C8, 16'h012C, 16'h0190);
        for (int c = 0; c < 4; c++) begin
            wr(spr_pkg::ADDR_MODE, 16'(c));
            for (int k = 0; k < 3; k++) begin
                feed(rtab[k]);
                check_outs(exp_dir(2'(c), rtab[k]));
            end
        end
        $display("test direction done");
        // band: filling uses the table, emptying its mirror about 150
        for (int c = 0; c < 2; c++) begin
            wr(spr_pkg::ADDR_MODE, (c == 1) ? 16'h0007 : 16'h0005);
            for (int k = 0; k < 5; k++) begin
                feed((c == 1) ? 16'h012C - ftab[k] : ftab[k]);
                check({15'h0000, relay_o[0]}, {15'h0000, pat[k]});
            end
        end
        $display("test band done");
        do_reset();
        set_thr(16'h0064, 16'h00C8, 16'h012C, 16'h0190);
        wr(spr_pkg::ADDR_MAKE_DELAY, 16'hFFFF);
        rd(spr_pkg::ADDR_MAKE_DELAY);
        check(d0, {2'h0, spr_pkg::MAX_DELAY});
        wr(spr_pkg::ADDR_MAKE_DELAY, 16'h0000);
        wr(spr_pkg::ADDR_BREAK_DELAY, 16'h0001);
        feed(16'h01F4);
        check_outs(4'hF);
        feed(16'h0032);
        check_outs(4'h1);
        do_reset();
        set_thr(16'h0064, 16'h00C8, 16'h012C, 16'h0190);
        wr(spr_pkg::ADDR_MAKE_DELAY, 16'h0001);
        feed(16'h01F4);
        repeat (40) @(posedge clk_i);
        #1 check_outs(4'hE);
        $display("test delay done");
        lock_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        trio(spr_pkg::ADDR_THRESHOLD_FIRST, 16'h0055);
        check(d0, thr[0]);
        check(d1, thr[0]);
        rd(spr_pkg::ADDR_STATUS);
        check(d0, 16'h01F0);
        lock_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        trio(spr_pkg::ADDR_THRESHOLD_FIRST, 16'h0055);
        check(d1, 16'h0055);
        $display("test lock done");
        // first threshold parked at the top so a high compare never fires
        set_thr(16'h270F, 16'h00C8, 16'h012C, 16'h0190);
        feed(16'h015E);
        check_outs(4'h6);
        wr(spr_pkg::ADDR_IRQ_STATUS, 16'h000F);
        rd(spr_pkg::ADDR_IRQ_STATUS);
        check(d0, 16'h0000);
        feed(16'h01F4);
        rd(spr_pkg::ADDR_IRQ_STATUS);
        check(d0, 16'h0008);
        check({15'h0000, irq_o}, 16'h0000);
        wr(spr_pkg::ADDR_IRQ_MASK, 16'h0008);
        repeat (2) @(posedge clk_i);
        #1 check({15'h0000, irq_o}, 16'h0001);
        wr(spr_pkg::ADDR_IRQ_STATUS, 16'h0008);
        repeat (2) @(posedge clk_i);
        #1 check({15'h0000, irq_o}, 16'h0000);
        $display("test interrupt done");
        stop_test();
    end
endmodule : spr_controller_tb

bind spr_controller spr_controller_properties i_spr_controller_properties (.clk_i(clk_i),
    .rst_i(rst_i), .reading_i(reading_i), .reading_valid_i(reading_valid_i),
    .lock_n_i(lock_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .relay_o(relay_o), .indicator_o(indicator_o), .irq_o(irq_o));

// file: test/spr_panel_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// relay coils and indicator lamps on the far side
// ------------------------------------------------------------
module spr_panel_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] relay_i,
    input wire logic [3:0] indicator_i,
    output logic [3:0] coil_o,
    output logic [3:0] lamp_o
);
    // coils pull in one clock after their drive, never sooner
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            coil_o <= 4'h0;
            lamp_o <= 4'h0;
        end else begin
            coil_o <= relay_i;
            lamp_o <= indicator_i;
        end
    end
endmodule : spr_panel_model
